// ==== src/scfg_pkg.sv ====
// ****************************************************************
// System configuration constants
// ****************************************************************
package scfg_pkg;
   // Register byte addresses on the 24-bit peripheral address
   localparam logic [23:0] MOD_CONFIG_ADDR = 24'hFF_F910;
   localparam logic [23:0] MOD_STATUS_ADDR = 24'hFF_F914;
   localparam logic [23:0] SOFT_RST_ADDR   = 24'hFF_F918;

   // Module config field positions
   localparam int CFG_EXT_IO_BIT  = 0;
   localparam int CFG_PLL_OE_BIT  = 1;
   localparam int CFG_MAIN_OE_BIT = 2;
   localparam int CFG_SLOW_OE_BIT = 3;
   localparam int CFG_MISC_SR_BIT = 5;
   localparam int CFG_MEM_SR_BIT  = 6;
   // Writable bits of module config, reserved bits read zero
   localparam logic [7:0] CFG_WR_MASK = 8'h6F;
   localparam logic [7:0] CFG_RESET   = 8'h00;

   // Module status field positions
   localparam int STAT_FBUSY_BIT  = 3;
   localparam int STAT_DFBUSY_BIT = 4;
   localparam int STAT_WD_BIT     = 6;
   localparam int STAT_ISP_BIT    = 7;

   // Soft reset key values
   localparam logic [7:0] KEY_FIRST = 8'hE1;
   localparam logic [7:0] KEY_ENTER = 8'h3E;
   localparam logic [7:0] KEY_LEAVE = 8'h0E;
   // Second write must come within this many cycles
   localparam logic [6:0] KEY_WINDOW_CYC = 7'h7F;
   // Boot region value meaning undefined
   localparam logic [3:0] BOOT_UNDEF = 4'hF;

   // Peripheral address windows
   localparam logic [23:0] PER0_LO = 24'h0E_F000;
   localparam logic [23:0] PER0_HI = 24'h0E_F1FF;
   localparam logic [23:0] PER1_LO = 24'hFF_0000;
   localparam logic [23:0] PER1_HI = 24'hFF_FBFF;
   localparam logic [23:0] IOZ_LO  = 24'hFF_FB00;
   localparam logic [23:0] IOZ_HI  = 24'hFF_FBFF;
   // Fixed peripheral access timing
   localparam logic [2:0] PER_WAIT_CYC = 3'h1;
   localparam logic [1:0] PER_HOLD_CYC = 2'h0;
   localparam logic       PER_PRE_IDLE = 1'b1;

   // Soft reset key sequencer states
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_ARMED = 2'b01,
      KEY_WAIT  = 2'b10
   } scfg_key_state_t;
endpackage

// ==== src/scfg_system_config.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// R1 - Peripheral access: one wait, one preidle, no hold
// R2 - I/O zone timing comes from its config
// R3 - Software writes config only in active mode
// R4 - Config bit 0 enables I/O zone external bus; here only while internalRomEnv is high
// R5 - Config bit 1 drives PLL clock on pin 0
// R6 - Config bit 2 drives main clock on pin 1
// R7 - Config bit 3 drives slow clock on pin 2
// R8 - Config bit 5 sets misc pin slew
// R9 - Config bit 6 sets memory pin slew
// R10 - Status 2:0 hold straps sampled at reset
// R11 - Status 3 mirrors flash busy
// R12 - Software starts no flash op while busy
// R13 - Status 4 mirrors data flash busy
// R14 - Software polls buffer full when data busy
// R15 - Status 6 watchdog flag, write one clears
// R16 - Status 7 set by programming mode reset
// R17 - Enter key honoured only when conditions hold
// R18 - E1h then 3Eh resets into programming mode
// R19 - Later resets stay in programming mode
// R20 - E1h then 0Eh resets out unconditionally
// R21 - Leave key cancels latched programming mode
// R22 - Soft reset waits while flash busy
// R23 - Bad or late second write abandons sequence
module scfg_system_config (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [23:0] regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic      [7:0]  regRdData_ff,
   // Strap and clock pins
   input  wire logic [2:0]  strapPinsIn,
   output logic      [2:0]  strapPinsOut_ff,
   output logic      [2:0]  strapPinsOe_ff,
   input  wire logic        pllClkIn,
   input  wire logic        mainClkIn,
   input  wire logic        slowClkIn,
   // Pad slew controls, high means slow
   output logic             miscIoSlowSlew_ff,
   output logic             memIoSlowSlew_ff,
   // Flash and watchdog status
   input  wire logic        flashCtrlBusy,
   input  wire logic        dataFlashBusy,
   input  wire logic        watchdogResetEvt,
   // Programming mode conditions
   input  wire logic        internalRomEnv,
   input  wire logic        externalRomEnv,
   input  wire logic [3:0]  bootRegionSize,
   input  wire logic        progCodePresent,
   // Soft reset outputs
   output logic             softResetReq_ff,
   output logic             progModeLatched_ff,
   // CPU access timing
   input  wire logic        cpuAccValid,
   input  wire logic [23:0] cpuAccAddr,
   input  wire logic [2:0]  ioZoneWait,
   input  wire logic [1:0]  ioZoneHold,
   input  wire logic        ioZonePreIdle,
   output logic             accPeriph_ff,
   output logic             accIoZone_ff,
   output logic      [2:0]  accWait_ff,
   output logic      [1:0]  accHold_ff,
   output logic             accPreIdle_ff,
   output logic             ioZoneExtBus_ff
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Inclusive address window test
   function automatic logic inWin(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
      inWin = (a >= lo) && (a <= hi);
   endfunction

   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************
   logic rstMeta_ff;  // First stage, read only by second
   logic rstSyncN;    // Released reset for the design

   // Release reset in step with the clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_ff <= 1'b0;
         rstSyncN   <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSyncN   <= rstMeta_ff;
      end
   end

   // ****************************************************************
   // Register decode
   // ****************************************************************
   logic       cfgWr;       // Write to module config
   logic       statWr;      // Write to module status
   logic       keyWr;       // Write to soft reset key
   logic [7:0] cfg_ff;      // Module config contents
   logic [2:0] strapState_ff;
   logic       strapDone_ff;
   logic       fBusy_ff;    // Flash busy copy
   logic       dfBusy_ff;   // Data flash busy copy
   logic       wdFlag_ff;   // Watchdog reset flag
   logic       ispFlag_ff;  // Programming mode reset flag
   logic [7:0] status;      // Assembled status byte

   assign cfgWr  = regWrStb && (regAddr == scfg_pkg::MOD_CONFIG_ADDR);
   assign statWr = regWrStb && (regAddr == scfg_pkg::MOD_STATUS_ADDR);
   assign keyWr  = regWrStb && (regAddr == scfg_pkg::SOFT_RST_ADDR);

   // ****************************************************************
   // Module config register
   // ****************************************************************
   // Held across power modes; only the register port writes it
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cfg_ff <= scfg_pkg::CFG_RESET;
      end else if (cfgWr) begin
         // Reserved bits stay zero
         cfg_ff <= regWrData & scfg_pkg::CFG_WR_MASK;
      end
   end

   // Pin drivers follow config one cycle later
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         strapPinsOe_ff    <= 3'h0;
         strapPinsOut_ff   <= 3'h0;
         miscIoSlowSlew_ff <= 1'b0;
         memIoSlowSlew_ff  <= 1'b0;
      end else begin
         strapPinsOe_ff[0] <= cfg_ff[scfg_pkg::CFG_PLL_OE_BIT];  // see R5
         strapPinsOe_ff[1] <= cfg_ff[scfg_pkg::CFG_MAIN_OE_BIT]; // see R6
         strapPinsOe_ff[2] <= cfg_ff[scfg_pkg::CFG_SLOW_OE_BIT]; // see R7
         // Clocks are resampled; enough for observation outputs
         strapPinsOut_ff   <= {slowClkIn, mainClkIn, pllClkIn};
         miscIoSlowSlew_ff <= cfg_ff[scfg_pkg::CFG_MISC_SR_BIT]; // see R8
         memIoSlowSlew_ff  <= cfg_ff[scfg_pkg::CFG_MEM_SR_BIT];  // see R9
      end
   end

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   // Sampled once on the first clock after release, then frozen;
   // drivers are off then since config resets to zero
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         strapDone_ff  <= 1'b0;
         strapState_ff <= 3'h0;
      end else if (!strapDone_ff) begin
         strapDone_ff  <= 1'b1;
         strapState_ff <= strapPinsIn; // see R10
      end
   end

   // ****************************************************************
   // Flash busy copies
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         fBusy_ff  <= 1'b0;
         dfBusy_ff <= 1'b0;
      end else begin
         fBusy_ff  <= flashCtrlBusy; // see R11
         dfBusy_ff <= dataFlashBusy; // see R13
      end
   end

   // ****************************************************************
   // Watchdog reset flag
   // ****************************************************************
   // Event wins over a clearing write in the same cycle
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         wdFlag_ff <= 1'b0;
      end else if (watchdogResetEvt) begin
         wdFlag_ff <= 1'b1; // see R15
      end else if (statWr && regWrData[scfg_pkg::STAT_WD_BIT]) begin
         wdFlag_ff <= 1'b0; // see R15
      end
   end

   // ****************************************************************
   // Soft reset key sequencer
   // ****************************************************************
   scfg_pkg::scfg_key_state_t keyState_ff; // Sequencer state
   logic [6:0] keyCnt_ff;    // Cycles since first key
   logic       enterOk;      // Entry conditions all met
   logic       inWindow;     // Second key still in time

   assign enterOk = (internalRomEnv || externalRomEnv)
                 && (bootRegionSize != scfg_pkg::BOOT_UNDEF)
                 && progCodePresent; // see R17
   assign inWindow = (keyCnt_ff <= scfg_pkg::KEY_WINDOW_CYC);

   // State and window counter
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         keyState_ff <= scfg_pkg::KEY_IDLE;
         keyCnt_ff   <= 7'h00;
      end else begin
         unique case (keyState_ff)
            scfg_pkg::KEY_IDLE: begin
               // Only the first key arms the sequence
               if (keyWr && regWrData == scfg_pkg::KEY_FIRST) begin
                  keyState_ff <= scfg_pkg::KEY_ARMED;
                  keyCnt_ff   <= 7'h01;
               end
            end
            scfg_pkg::KEY_ARMED: begin
               if (keyWr) begin
                  if (regWrData == scfg_pkg::KEY_LEAVE) begin
                     keyState_ff <= scfg_pkg::KEY_WAIT; // see R20
                  end else if (regWrData == scfg_pkg::KEY_ENTER
                               && enterOk) begin
                     keyState_ff <= scfg_pkg::KEY_WAIT; // see R18
                  end else begin
                     // Wrong key or unmet conditions
                     keyState_ff <= scfg_pkg::KEY_IDLE; // see R23
                  end
               end else if (keyCnt_ff == scfg_pkg::KEY_WINDOW_CYC) begin
                  // Window expired without a second key
                  keyState_ff <= scfg_pkg::KEY_IDLE; // see R23
               end else begin
                  keyCnt_ff <= keyCnt_ff + 7'h01;
               end
            end
            scfg_pkg::KEY_WAIT: begin
               // Hold the reset back until flash is quiet
               if (!(fBusy_ff || dfBusy_ff)) begin
                  keyState_ff <= scfg_pkg::KEY_IDLE; // see R22
               end
            end
            default: begin
               keyState_ff <= scfg_pkg::KEY_IDLE;
            end
         endcase
      end
   end

   logic keyAccept; // Valid second key this cycle
   logic keyEnter;  // Accepted enter sequence
   logic keyLeave;  // Accepted leave sequence

   assign keyAccept = keyWr && (keyState_ff == scfg_pkg::KEY_ARMED)
                   && inWindow;
   assign keyEnter  = keyAccept && enterOk
                   && (regWrData == scfg_pkg::KEY_ENTER);
   assign keyLeave  = keyAccept && (regWrData == scfg_pkg::KEY_LEAVE);

   // Reset request pulse, issued once flash has finished
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         softResetReq_ff <= 1'b0;
      end else begin
         softResetReq_ff <= (keyState_ff == scfg_pkg::KEY_WAIT)
                         && !(fBusy_ff || dfBusy_ff); // see R22
      end
   end

   // Programming mode latch and flag; only the leave key or a power-on
   // or external reset on reset_n clears them, so they survive soft resets
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         progModeLatched_ff <= 1'b0;
         ispFlag_ff         <= 1'b0;
      end else if (keyEnter) begin
         progModeLatched_ff <= 1'b1; // see R19
         ispFlag_ff         <= 1'b1; // see R16
      end else if (keyLeave) begin
         progModeLatched_ff <= 1'b0; // see R21
         ispFlag_ff         <= 1'b0; // see R16
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      status = 8'h00;
      status[2:0] = strapState_ff;
      status[scfg_pkg::STAT_FBUSY_BIT]  = fBusy_ff;
      status[scfg_pkg::STAT_DFBUSY_BIT] = dfBusy_ff;
      status[scfg_pkg::STAT_WD_BIT]     = wdFlag_ff;
      status[scfg_pkg::STAT_ISP_BIT]    = ispFlag_ff;
   end

   // Read data in the cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         regRdData_ff <= 8'h00;
      end else if (regRdStb && regAddr == scfg_pkg::MOD_CONFIG_ADDR) begin
         regRdData_ff <= cfg_ff;
      end else if (regRdStb && regAddr == scfg_pkg::MOD_STATUS_ADDR) begin
         regRdData_ff <= status;
      end else begin
         // Key register is write only; unmapped reads zero
         regRdData_ff <= 8'h00;
      end
   end

   // ****************************************************************
   // CPU access timing
   // ****************************************************************
   logic isIoZone;  // Address in I/O zone
   logic isPeriph;  // Address in fixed timing window

   assign isIoZone = inWin(cpuAccAddr, scfg_pkg::IOZ_LO, scfg_pkg::IOZ_HI);
   assign isPeriph = inWin(cpuAccAddr, scfg_pkg::PER0_LO, scfg_pkg::PER0_HI)
                  || inWin(cpuAccAddr, scfg_pkg::PER1_LO, scfg_pkg::PER1_HI);

   // Timing answer one cycle after the access address
   always_ff @(posedge core_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         accPeriph_ff    <= 1'b0;
         accIoZone_ff    <= 1'b0;
         accWait_ff      <= 3'h0;
         accHold_ff      <= 2'h0;
         accPreIdle_ff   <= 1'b0;
         ioZoneExtBus_ff <= 1'b0;
      end else begin
         accPeriph_ff    <= cpuAccValid && isPeriph;
         accIoZone_ff    <= cpuAccValid && isIoZone;
         ioZoneExtBus_ff <= cpuAccValid && isIoZone && internalRomEnv
                         && cfg_ff[scfg_pkg::CFG_EXT_IO_BIT]; // see R4
         if (cpuAccValid && isIoZone) begin
            accWait_ff    <= ioZoneWait;    // see R2
            accHold_ff    <= ioZoneHold;    // see R2
            accPreIdle_ff <= ioZonePreIdle; // see R2
         end else if (cpuAccValid && isPeriph) begin
            accWait_ff    <= scfg_pkg::PER_WAIT_CYC; // see R1
            accHold_ff    <= scfg_pkg::PER_HOLD_CYC; // see R1
            accPreIdle_ff <= scfg_pkg::PER_PRE_IDLE; // see R1
         end else begin
            accWait_ff    <= 3'h0;
            accHold_ff    <= 2'h0;
            accPreIdle_ff <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstSyncN);

   AST_PERIPH_TIMING: assert property ( // see R1
      cpuAccValid && isPeriph && !isIoZone |=>
      accWait_ff == 3'h1 && accHold_ff == 2'h0 && accPreIdle_ff)
      else $error("peripheral timing wrong");
   AST_IOZONE_TIMING: assert property ( // see R2
      cpuAccValid && isIoZone |=>
      accWait_ff == $past(ioZoneWait) && accIoZone_ff)
      else $error("io zone timing not from config");
   AST_PLL_OE: assert property ( // see R5
      cfgWr |=> ##1 strapPinsOe_ff[0] == $past(regWrData[1], 2))
      else $error("pll clock enable not applied");
   AST_STRAP_HOLD: assert property ( // see R10
      strapDone_ff && $past(strapDone_ff) |-> $stable(strapState_ff))
      else $error("strap state changed");
   AST_BUSY_COPY: assert property ( // see R11
      ##1 status[3] == $past(flashCtrlBusy) &&
      status[4] == $past(dataFlashBusy))
      else $error("busy copy wrong");
   AST_WD_SET: assert property ( // see R15
      watchdogResetEvt |=> wdFlag_ff)
      else $error("watchdog flag lost");
   AST_WD_CLEAR: assert property ( // see R15
      statWr && regWrData[6] && !watchdogResetEvt |=> !wdFlag_ff)
      else $error("watchdog flag not cleared");
   AST_ENTER_BLOCKED: assert property ( // see R17
      keyWr && keyState_ff == scfg_pkg::KEY_ARMED && !enterOk &&
      regWrData == 8'h3E |=> keyState_ff == scfg_pkg::KEY_IDLE
      ##1 !softResetReq_ff)
      else $error("enter honoured without conditions");
   AST_ENTER_RESET: assert property ( // see R18
      keyEnter && !flashCtrlBusy && !dataFlashBusy ##1
      !fBusy_ff && !dfBusy_ff |=> softResetReq_ff && progModeLatched_ff)
      else $error("enter sequence did not reset");
   AST_LEAVE_CLEARS: assert property ( // see R21
      keyLeave |=> !progModeLatched_ff && !ispFlag_ff)
      else $error("leave did not cancel latch");
   AST_FLASH_DEFER: assert property ( // see R22
      softResetReq_ff |-> !$past(fBusy_ff) && !$past(dfBusy_ff))
      else $error("reset issued while flash busy");
   AST_KEY_TIMEOUT: assert property ( // see R23
      keyState_ff == scfg_pkg::KEY_ARMED && keyCnt_ff == 7'h7F && !keyWr
      |=> keyState_ff == scfg_pkg::KEY_IDLE)
      else $error("late key not abandoned");

   COV_ENTER: cover property (keyEnter ##[1:20] softResetReq_ff);
   COV_LEAVE: cover property (keyLeave ##1 softResetReq_ff);
   COV_DEFER: cover property (keyState_ff == scfg_pkg::KEY_WAIT
                              && fBusy_ff);
   COV_TIMEOUT: cover property (keyState_ff == scfg_pkg::KEY_ARMED
                                && keyCnt_ff == 7'h7F && !keyWr);

endmodule

// ==== bench/scfg_system_config_tb_top.sv ====
`timescale 1ns/100ps
// ***************************************************
// Bench for the system configuration block
// ***************************************************
module scfg_system_config_tb_top;
   localparam logic [23:0] CFGA = scfg_pkg::MOD_CONFIG_ADDR;
   localparam logic [23:0] STAA = scfg_pkg::MOD_STATUS_ADDR;
   localparam logic [23:0] KEYA = scfg_pkg::SOFT_RST_ADDR;
   logic        core_clk, reset_n, regWrStb, regRdStb, pllClkIn;
   logic        mainClkIn, slowClkIn, flashCtrlBusy, dataFlashBusy;
   logic        watchdogResetEvt, internalRomEnv, externalRomEnv;
   logic        progCodePresent, cpuAccValid, ioZonePreIdle;
   logic        miscIoSlowSlew_ff, memIoSlowSlew_ff, softResetReq_ff;
   logic        progModeLatched_ff, accPeriph_ff, accIoZone_ff;
   logic        accPreIdle_ff, ioZoneExtBus_ff;
   logic [23:0] regAddr, cpuAccAddr;
   logic [7:0]  regWrData, regRdData_ff, rdv;
   logic [2:0]  strapPinsIn, strapPinsOut_ff, strapPinsOe_ff;
   logic [2:0]  ioZoneWait, accWait_ff;
   logic [1:0]  ioZoneHold, accHold_ff;
   logic [3:0]  bootRegionSize;
   logic [2:0]  lastClk;  // Clock pin inputs seen one cycle back
   logic        live;     // Pin compare armed once out of reset
   logic [31:0] seed;
   // Window edges inside both ends of each peripheral range, outside only the upper ends
   logic [23:0] al [8] = '{24'hFF_0000, 24'hFF_FB00, 24'hFF_FBFF,
      24'h0E_F1FF, 24'h0E_F200, 24'hFF_FC00, 24'h0E_F000, 24'h00_0000};
   int          failures, comparisons, pulses, module_config, mWd, mIsp, mStrap;
   int          p, n;

   scfg_system_config uut (.*);

   // Free running clock, 25 ns period
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Count reset pulses away from the edge to avoid a race
   always @(negedge core_clk) begin
      if (softResetReq_ff === 1'b1)
         pulses++;
      if (live)
         chk("clock pins", lastClk, strapPinsOut_ff);
      lastClk = {slowClkIn, mainClkIn, pllClkIn};
   end

   // Pin clock sources keep moving so the resample path is exercised
   always @(posedge core_clk) begin
      {pllClkIn, mainClkIn, slowClkIn} <= 3'(rnd());
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Model of the status byte
   function automatic logic [7:0] stat();
      return {mIsp[0], mWd[0], 1'b0, dataFlashBusy, flashCtrlBusy,
              mStrap[2:0]};
   endfunction

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus cycle then one idle cycle; read data kept in rdv
   task automatic acc(logic w, logic [23:0] a, logic [7:0] d);
      regWrStb  <= w;
      regRdStb  <= !w;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      #1 rdv = regRdData_ff;
      @(posedge core_clk);
   endtask

   task automatic rd(logic [23:0] a, logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("read data", e, rdv);
   endtask

   // Two write key sequence, gap plus one idle cycles between the writes
   task automatic key(logic [7:0] v, int gap, logic ex);
      p = pulses;
      acc(1'b1, KEYA, scfg_pkg::KEY_FIRST);
      repeat (gap) @(posedge core_clk);
      acc(1'b1, KEYA, v);
      #1 chk("reset pulse", ex, softResetReq_ff);
      repeat (3) @(posedge core_clk);
      chk("pulse count", p + ex, pulses);
   endtask

   // CPU access timing against the window model
   task automatic at(logic [23:0] a);
      int io, pe;
      io = (a >= 24'hFF_FB00 && a <= 24'hFF_FBFF);
      pe = io || (a >= 24'h0E_F000 && a <= 24'h0E_F1FF)
              || (a >= 24'hFF_0000 && a <= 24'hFF_FBFF);
      cpuAccValid <= 1'b1;
      cpuAccAddr  <= a;
      @(posedge core_clk);
      cpuAccValid <= 1'b0;
      #1 chk("periph", pe, accPeriph_ff);
      chk("iozone", io, accIoZone_ff);
      chk("wait", io ? ioZoneWait : pe, accWait_ff);
      chk("hold", io ? ioZoneHold : 0, accHold_ff);
      chk("preidle", io ? ioZonePreIdle : pe, accPreIdle_ff);
      chk("extbus", io & internalRomEnv & module_config[0], ioZoneExtBus_ff);
      @(posedge core_clk);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      seed = 32'h5c19;
      {failures, comparisons, pulses, module_config, mWd, mIsp} = '0;
      reset_n = 1'b0;
      {regWrStb, regRdStb, cpuAccValid, watchdogResetEvt, live} = '0;
      {regAddr, regWrData, cpuAccAddr} = '0;
      {flashCtrlBusy, dataFlashBusy, externalRomEnv} = '0;
      {pllClkIn, mainClkIn, slowClkIn, ioZonePreIdle} = '0;
      internalRomEnv  = 1'b1;
      progCodePresent = 1'b1;
      bootRegionSize  = 4'h3;
      ioZoneWait      = 3'h5;
      ioZoneHold      = 2'h2;
      strapPinsIn     = 3'(rnd());
      mStrap          = int'(strapPinsIn);
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      live = 1'b1;
      // Later strap changes must not reach the status byte
      strapPinsIn <= ~strapPinsIn;
      rd(CFGA, scfg_pkg::CFG_RESET);
      rd(STAA, stat());
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         rdv = (i == 0) ? 8'hFF : 8'(rnd());
         module_config = int'(rdv & scfg_pkg::CFG_WR_MASK);
         acc(1'b1, CFGA, rdv);
         rd(CFGA, 8'(module_config));
         chk("clock oe", module_config[3:1], strapPinsOe_ff);
         chk("misc slew", module_config[5], miscIoSlowSlew_ff);
         chk("mem slew", module_config[6], memIoSlowSlew_ff);
      end
      // Unmapped place and the write only key register read zero
      acc(1'b1, 24'hFF_F91C, 8'hFF);
      rd(24'hFF_F91C, 8'h00);
      rd(KEYA, 8'h00);
      rd(CFGA, 8'(module_config));
      $display("test config register done");
      for (int i = 0; i < 4; i++) begin
         // No flash work is started from here while busy
         {dataFlashBusy, flashCtrlBusy} <= 2'(i);
         @(posedge core_clk);
         @(posedge core_clk);
         rd(STAA, stat());
      end
      {dataFlashBusy, flashCtrlBusy} <= 2'b00;
      watchdogResetEvt <= 1'b1;
      @(posedge core_clk);
      watchdogResetEvt <= 1'b0;
      mWd = 1;
      @(posedge core_clk);
      rd(STAA, stat());
      acc(1'b1, STAA, 8'hBF);
      rd(STAA, stat());
      acc(1'b1, STAA, 8'h40);
      mWd = 0;
      rd(STAA, stat());
      $display("test status register done");
      // Enter then leave, once from each ROM environment
      for (int j = 0; j < 2; j++) begin
         internalRomEnv <= (j == 0);
         externalRomEnv <= (j == 1);
         key(scfg_pkg::KEY_ENTER, 120 * j, 1'b1);
         mIsp = 1;
         chk("latched", 1, progModeLatched_ff);
         rd(STAA, stat());
         key(scfg_pkg::KEY_LEAVE, 0, 1'b1);
         mIsp = 0;
         chk("latched", 0, progModeLatched_ff);
         rd(STAA, stat());
      end
      internalRomEnv <= 1'b1;
      externalRomEnv <= 1'b0;
      // Each unmet condition refuses the enter sequence
      for (int i = 0; i < 3; i++) begin
         internalRomEnv  <= (i != 0);
         bootRegionSize  <= (i == 1) ? scfg_pkg::BOOT_UNDEF : 4'h3;
         progCodePresent <= (i != 2);
         key(scfg_pkg::KEY_ENTER, 0, 1'b0);
         chk("latched", 0, progModeLatched_ff);
      end
      internalRomEnv  <= 1'b1;
      progCodePresent <= 1'b1;
      bootRegionSize  <= 4'h3;
      key(8'h55, 0, 1'b0);
      key(scfg_pkg::KEY_FIRST, 0, 1'b0);
      key(scfg_pkg::KEY_LEAVE, 130, 1'b0);
      $display("test key sequences done");
      // Busy flash holds the reset back until it goes idle
      dataFlashBusy <= 1'b1;
      p = pulses;
      acc(1'b1, KEYA, scfg_pkg::KEY_FIRST);
      acc(1'b1, KEYA, scfg_pkg::KEY_LEAVE);
      repeat (8) @(posedge core_clk);
      chk("held pulse", p, pulses);
      dataFlashBusy <= 1'b0;
      n = 0;
      while (pulses == p && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      chk("delayed pulse", p + 1, pulses);
      if (n == 20)
         give_verdict();
      $display("test busy delay done");
      for (int j = 0; j < 2; j++) begin
         module_config = 1 - j;
         acc(1'b1, CFGA, 8'(module_config));
         for (int i = 0; i < 8; i++)
            at(al[i]);
         at(24'(rnd()));
      end
      $display("test access timing done");
      give_verdict();
   end
endmodule
